// ==== bio_pkg.sv ====
/*
 Package for the bytewise I/O port block: register map, field layout,
 reset values and the pin configuration carrier.
 Assumes an AXI4-Lite master with 32-bit data on the same clock.
*/
package bio_pkg;
   // =========================================================
   // Register map (byte addresses)
   localparam logic [7:0] BIO_OFS_LEVEL    = 8'h00;
   localparam logic [7:0] BIO_OFS_DIR      = 8'h04;
   localparam logic [7:0] BIO_OFS_OPTION   = 8'h08;
   localparam logic [7:0] BIO_OFS_IRQCFG   = 8'h0C;
   localparam logic [7:0] BIO_OFS_IRQSTAT  = 8'h10;
   localparam logic [7:0] BIO_OFS_PINS     = 8'h14;
   localparam logic [7:0] BIO_OFS_PWM      = 8'h18;
   // =========================================================
   // Field positions and reset values
   localparam int         BIO_IRQCFG_LEVEL_BIT = 0;
   localparam int         BIO_IRQCFG_RISE_BIT  = 1;
   localparam logic [7:0] BIO_PORT_RST         = 8'h00;
   localparam logic [1:0] BIO_RESP_OKAY        = 2'h0;
   localparam logic [1:0] BIO_RESP_SLVERR      = 2'h2;
   // Index of the line that the timer PWM output may take over
   localparam int         BIO_PWM_LINE         = 7;
   // =========================================================
   // Per-port pin configuration
   typedef struct packed {
      logic [7:0] out_val;
      logic [7:0] out_en;
      logic [7:0] pullup_en;
      logic [7:0] analog_sel;
   } bio_pad_t;
endpackage

// ==== bio_port.sv ====
/*
 Bytewise I/O port: level, direction and option registers over AXI4-Lite,
 pin mode decode, input synchronising, interrupt request generation.
 Assumes pins arrive asynchronously; the pad cell does the pull-up and
 the open-drain/push-pull drive from the enables given here.
*/
//Contract
// R1 - Three registers, bit n controls line n
// R2 - Registers read and write like RAM
// R3 - Level read returns pin on inputs
// R4 - Written level drives output lines
// R5 - Input read pin; latch sets characteristics
// R6 - Direction bit: 0 input, 1 output
// R7 - Option bit selects mode option
// R8 - Reset clears all: input with pull-up
// R9 - Dir0 opt0: input, latch selects pull-up
// R10 - Dir0 opt1 latch0: pull-up with interrupt
// R11 - Dir0 opt1 latch1: analog input
// R12 - Dir1 opt0: open-drain output
// R13 - Dir1 opt1: push-pull output
// R14 - No pull-up input left high impedance
// R15 - Falling, rising or low level trigger
// R16 - Analog lines reach converter multiplexer
// R17 - Software selects one analog line only
// R18 - Software avoids bit read-modify-write
// R19 - Software uses safe mode transitions
// R20 - Software masks unimplemented bits
// R21 - Edge or level, polarity selectable; the level trigger here is low only
// R22 - PWM enable overrides timer pin
// R23 - Pins synchronised before use
`timescale 1ns/10ps
module bio_port
   import bio_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [7:0]  pin_in,
   output logic [7:0]       pin_out,
   output logic [7:0]       pin_oe,
   output logic [7:0]       pin_pullup,
   output logic [7:0]       analog_sel,
   input  wire logic        pwm_output_enable,
   input  wire logic        timer_pwm_pin,
   output logic             port_irq
);
   // =========================================================
   // Registers
   logic [7:0] port_level_reg, port_direction_reg, port_option_reg;  // R1
   logic [1:0] irqcfg_reg;
   logic [7:0] irq_stat_reg, irq_stat_next;
   logic [7:0] sync1_reg, sync2_reg, sync3_reg, pin_reg, pin_prev_reg;
   logic       aw_got_reg, w_got_reg;
   logic [7:0] awaddr_reg;
   logic [7:0] wdata_reg;
   logic       wstrb0_reg;
   bio_pad_t   pad_next;
   logic [7:0] impl_mask;

   assign impl_mask = 8'((9'h001 << WIDTH) - 9'h001);

   // =========================================================
   // Pin synchroniser: change counts once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Idle level of a pulled-up pin, so no false edge follows reset
         sync1_reg    <= 8'hFF;
         sync2_reg    <= 8'hFF;
         sync3_reg    <= 8'hFF;
         pin_reg      <= 8'hFF;
         pin_prev_reg <= 8'hFF;
      end else begin
         sync1_reg    <= pin_in;                                      // R23
         sync2_reg    <= sync1_reg;
         sync3_reg    <= sync2_reg;
         pin_reg      <= (sync2_reg & sync3_reg) | (pin_reg & (sync2_reg | sync3_reg));
         pin_prev_reg <= pin_reg;
      end
   end

   // =========================================================
   // Mode decode per line
   logic [7:0] is_in, irq_line;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_line
         wire dir = port_direction_reg[gi];
         wire opt = port_option_reg[gi];
         wire lat = port_level_reg[gi];
         assign is_in[gi]              = !dir;                        // R6
         assign irq_line[gi]           = !dir && opt && !lat;         // R10
         assign pad_next.pullup_en[gi] = !dir && !lat;                // R9 R10 R14
         assign pad_next.analog_sel[gi] = !dir && opt && lat;         // R11 R16
         // Open drain drives only a low; push-pull drives both levels
         assign pad_next.out_en[gi]    = dir && (opt || !lat);        // R12 R13
         assign pad_next.out_val[gi]   = dir && lat;                  // R4
      end
   endgenerate

   // =========================================================
   // Pad drive, with the PWM takeover of the timer line
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out    <= 8'h00;
         pin_oe     <= 8'h00;
         pin_pullup <= 8'hFF;                                         // R8
         analog_sel <= 8'h00;
      end else begin
         pin_out    <= pad_next.out_val & impl_mask;
         pin_oe     <= pad_next.out_en & impl_mask;
         pin_pullup <= pad_next.pullup_en & impl_mask;
         analog_sel <= pad_next.analog_sel & impl_mask;
         if (pwm_output_enable) begin                                 // R22
            pin_out[BIO_PWM_LINE]    <= timer_pwm_pin;
            pin_oe[BIO_PWM_LINE]     <= 1'b1;
            pin_pullup[BIO_PWM_LINE] <= 1'b0;
            analog_sel[BIO_PWM_LINE] <= 1'b0;
         end
      end
   end

   // =========================================================
   // Interrupt detection: level-low, falling or rising edge
   logic [7:0] ev_fall, ev_rise, ev_edge;
   logic       lvl_mode;
   assign lvl_mode = irqcfg_reg[BIO_IRQCFG_LEVEL_BIT];
   assign ev_fall  = pin_prev_reg & ~pin_reg;
   assign ev_rise  = ~pin_prev_reg & pin_reg;
   assign ev_edge  = irqcfg_reg[BIO_IRQCFG_RISE_BIT] ? ev_rise : ev_fall;  // R15 R21

   // =========================================================
   // AXI4-Lite write path
   logic       wr_fire, wr_sel_level, wr_sel_dir, wr_sel_opt, wr_sel_cfg;
   logic       wr_sel_stat, wr_hit;
   assign wr_fire      = aw_got_reg && w_got_reg && !s_axi_bvalid;
   assign wr_sel_level = awaddr_reg == BIO_OFS_LEVEL;
   assign wr_sel_dir   = awaddr_reg == BIO_OFS_DIR;
   assign wr_sel_opt   = awaddr_reg == BIO_OFS_OPTION;
   assign wr_sel_cfg   = awaddr_reg == BIO_OFS_IRQCFG;
   assign wr_sel_stat  = awaddr_reg == BIO_OFS_IRQSTAT;
   assign wr_hit       = wr_sel_level | wr_sel_dir | wr_sel_opt | wr_sel_cfg | wr_sel_stat
                         | (awaddr_reg == BIO_OFS_PINS) | (awaddr_reg == BIO_OFS_PWM);

   // Sticky edge flags; an edge in the clearing cycle wins over the clear
   always_comb begin
      irq_stat_next = irq_stat_reg;
      if (wr_fire && wr_sel_stat && wstrb0_reg)
         irq_stat_next = irq_stat_reg & ~wdata_reg;
      irq_stat_next = (irq_stat_next | (ev_edge & irq_line)) & irq_line & impl_mask;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= BIO_RESP_OKAY;
         aw_got_reg    <= 1'b0;
         w_got_reg     <= 1'b0;
         awaddr_reg    <= 8'h00;
         wdata_reg     <= 8'h00;
         wstrb0_reg    <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg    <= 1'b1;
            awaddr_reg    <= {s_axi_awaddr[7:2], 2'b00};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg    <= 1'b1;
            wdata_reg    <= s_axi_wdata[7:0];
            wstrb0_reg   <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? BIO_RESP_OKAY : BIO_RESP_SLVERR;
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Port registers: cleared at reset, written as plain storage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_level_reg     <= BIO_PORT_RST;                          // R8
         port_direction_reg <= BIO_PORT_RST;
         port_option_reg    <= BIO_PORT_RST;
         irqcfg_reg         <= 2'b00;
         irq_stat_reg       <= 8'h00;
      end else begin
         irq_stat_reg <= irq_stat_next;
         if (wr_fire && wstrb0_reg) begin                             // R2
            if (wr_sel_level)
               port_level_reg <= wdata_reg & impl_mask;               // R4 R5
            if (wr_sel_dir)
               port_direction_reg <= wdata_reg & impl_mask;           // R6
            if (wr_sel_opt)
               port_option_reg <= wdata_reg & impl_mask;              // R7
            if (wr_sel_cfg)
               irqcfg_reg <= wdata_reg[1:0];
         end
      end
   end

   // Interrupt request: sticky edges, or live low level in level mode
   always_ff @(posedge aclk) begin
      if (!aresetn)
         port_irq <= 1'b0;
      else if (lvl_mode)
         port_irq <= |(irq_line & ~pin_reg & impl_mask);               // R15 R21
      else
         port_irq <= |irq_stat_next;
   end

   // =========================================================
   // AXI4-Lite read path
   logic [7:0] rd_level, rd_byte;
   logic       rd_hit;
   logic [7:0] ar_addr;
   assign ar_addr  = {s_axi_araddr[7:2], 2'b00};
   assign rd_level = ((pin_reg & is_in) | (port_level_reg & ~is_in)) & impl_mask;  // R3 R5
   assign rd_hit   = (ar_addr <= BIO_OFS_PWM);
   always_comb begin
      rd_byte = 8'h00;
      unique case (ar_addr)
         BIO_OFS_LEVEL:   rd_byte = rd_level;
         BIO_OFS_DIR:     rd_byte = port_direction_reg;
         BIO_OFS_OPTION:  rd_byte = port_option_reg;
         BIO_OFS_IRQCFG:  rd_byte = {6'h00, irqcfg_reg};
         BIO_OFS_IRQSTAT: rd_byte = irq_stat_reg;
         BIO_OFS_PINS:    rd_byte = pin_reg & impl_mask;
         BIO_OFS_PWM:     rd_byte = {7'h00, pwm_output_enable};
         default:         rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= BIO_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h00_0000, rd_byte};
         s_axi_rresp   <= rd_hit ? BIO_RESP_OKAY : BIO_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // =========================================================
   // Checks
   AST_RESET_PULLUP: assert property (@(posedge aclk)                 // R8
      $rose(aresetn) |-> pin_pullup == impl_mask && pin_oe == 8'h00)
      else $error("pull-ups not all on after reset");
   AST_OPEN_DRAIN: assert property (@(posedge aclk) disable iff (!aresetn)  // R12
      (!pwm_output_enable && port_direction_reg[4] && !port_option_reg[4]
       && port_level_reg[4]) |=> (pin_oe[4] == 1'b0))
      else $error("open drain line drives high");
   AST_PUSH_PULL: assert property (@(posedge aclk) disable iff (!aresetn)   // R13
      (port_direction_reg[6] && port_option_reg[6])
      |=> (pin_oe[6] && pin_out[6] == $past(port_level_reg[6])))
      else $error("push-pull line not driven from latch");
   AST_HIGHZ: assert property (@(posedge aclk) disable iff (!aresetn)       // R14
      (!port_direction_reg[1] && port_level_reg[1]) |=> (!pin_oe[1] && !pin_pullup[1]))
      else $error("input without pull-up not high impedance");
   AST_ANALOG: assert property (@(posedge aclk) disable iff (!aresetn)      // R11
      (!port_direction_reg[2] && port_option_reg[2] && port_level_reg[2])
      |=> analog_sel[2])
      else $error("analog line not routed");
   AST_PWM: assert property (@(posedge aclk) disable iff (!aresetn)         // R22
      pwm_output_enable |=> (pin_oe[7] && pin_out[7] == $past(timer_pwm_pin)))
      else $error("pwm does not own timer pin");
   AST_SYNC: assert property (@(posedge aclk) disable iff (!aresetn)        // R23
      ((pin_reg ^ $past(pin_reg)) & ($past(sync2_reg) ^ $past(sync3_reg))) == 8'h00)
      else $error("pin level changed without agreement");
   AST_EDGE_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)    // R15
      (!lvl_mode && |(ev_edge & irq_line)) |=> port_irq)
      else $error("edge did not raise interrupt");
   AST_INPUT_READ: assert property (@(posedge aclk) disable iff (!aresetn)  // R3
      (s_axi_arvalid && s_axi_arready && ar_addr == BIO_OFS_LEVEL && is_in[3])
      |=> s_axi_rdata[3] == $past(pin_reg[3]))
      else $error("input read does not return pin");
   AST_LEVEL_READ_OUT: assert property (@(posedge aclk) disable iff (!aresetn)  // R4
      (s_axi_arvalid && s_axi_arready && ar_addr == BIO_OFS_LEVEL && !is_in[6])
      |=> s_axi_rdata[6] == $past(port_level_reg[6]))
      else $error("output read does not return latch");
   // Mode decode per line, and register clear at reset
   AST_INPUT_NO_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn)  // R6
      !port_direction_reg[0] |=> !pin_oe[0])
      else $error("input line is driven");
   AST_PULLUP_ON: assert property (@(posedge aclk) disable iff (!aresetn)       // R9
      (!port_direction_reg[1] && !port_level_reg[1]) |=> pin_pullup[1])
      else $error("pull-up missing on input");
   AST_OD_LOW: assert property (@(posedge aclk) disable iff (!aresetn)          // R12
      (port_direction_reg[5] && !port_option_reg[5] && !port_level_reg[5])
      |=> (pin_oe[5] && !pin_out[5]))
      else $error("open drain line does not pull low");
   AST_NO_ANALOG_OUT: assert property (@(posedge aclk) disable iff (!aresetn)   // R16
      port_direction_reg[4] |=> !analog_sel[4])
      else $error("output line routed to converter");
   AST_RESET_CLEAR: assert property (@(posedge aclk)                            // R8
      $rose(aresetn) |-> port_level_reg == BIO_PORT_RST && port_direction_reg == BIO_PORT_RST
      && port_option_reg == BIO_PORT_RST && !port_irq)
      else $error("port registers not cleared by reset");
   // Interrupt request
   AST_LEVEL_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)       // R21
      (lvl_mode && |(irq_line & ~pin_reg & impl_mask))
      |=> port_irq)
      else $error("low level did not raise interrupt");
   AST_EDGE_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)      // R15
      (!lvl_mode && irq_stat_next == 8'h00) |=> !port_irq)
      else $error("interrupt without pending flag");
   // Bus handshake
   AST_WR_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)       // R2
      wr_fire |=> s_axi_bvalid)
      else $error("write not answered");
   AST_RD_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)       // R2
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
      else $error("read not answered");
endmodule // bio_port

// ==== bio_pin_model.sv ====
/*
 Pin-side model for the bytewise I/O port: resolves each line from the
 port drive, an external driver and the pull-up.
 Assumes the bench enables its external driver only on input lines.
*/
`timescale 1ns/10ps
module bio_pin_model (
   input  wire logic       aclk,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pin_pullup,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] pin_in
);
   logic [7:0] float_reg = 8'h5A;
   // Undriven lines without pull-up wander every cycle
   always_ff @(posedge aclk) begin
      float_reg <= ~float_reg;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i]) begin
            pin_in[i] = pin_out[i];
         end else if (ext_en[i]) begin
            pin_in[i] = ext_val[i];
         end else if (pin_pullup[i]) begin
            pin_in[i] = 1'b1;
         end else begin
            pin_in[i] = float_reg[i];
         end
      end
   end
endmodule // bio_pin_model

// ==== test_bio_port.sv ====
/*
 Self-checking bench for the bytewise I/O port: AXI4-Lite register tasks,
 pin model, mode table, interrupts, PWM takeover and reset.
 Assumes the port and pin model files are compiled before this one.
*/
`timescale 1ns/10ps
module test_bio_port;
   import bio_pkg::*;
   logic aclk = 1'b0, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
   logic bvalid, arready, rvalid, irq, pwm_en, pwm_val;
   logic [7:0]  awaddr, araddr, pin_in, pin_out, pin_oe, pin_pullup, analog_sel, ext_en, ext_val;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rd;
   int          bad_count = 0, num_checks = 0;
   logic [7:0]  p_lvl[2] = '{8'h55, 8'hAA}, p_pu[2] = '{8'h0A, 8'h05};
   logic [7:0]  p_an[2] = '{8'h04, 8'h08}, p_oe[2] = '{8'hE0, 8'hD0}, p_out[2] = '{8'h40, 8'h80};
   always #20 aclk = ~aclk;
   bio_port dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .analog_sel(analog_sel),
      .pwm_output_enable(pwm_en), .timer_pwm_pin(pwm_val), .port_irq(irq));
   bio_pin_model pins_u (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
   // =========================================================
   // Bench tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Whole-byte writes only, so no line is reprogrammed from pin levels
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata; resp = rresp;
      rready <= 1'b0;
   endtask
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask
   task automatic wait_irq(input logic v);
      for (int n = 0; n < 10 && irq !== v; n++) @(posedge aclk);
      check(32'(irq), 32'(v));
   endtask
   // =========================================================
   // Tests
   initial begin
      awvalid <= 1'b0; wvalid <= 1'b0; bready <= 1'b0; arvalid <= 1'b0;
      rready <= 1'b0; awaddr <= 8'h00; araddr <= 8'h00; wdata <= 32'h0; wstrb <= 4'h0;
      pwm_en <= 1'b0; pwm_val <= 1'b0; ext_en <= 8'h00; ext_val <= 8'h00;
      do_reset();
      check(32'(pin_pullup), 32'hFF);
      check(32'({pin_oe, analog_sel, 7'h0, irq}), 32'h0);
      axi_read(BIO_OFS_LEVEL); check(rd, 32'hFF);
      axi_read(BIO_OFS_DIR); check(rd, 32'h0);
      axi_read(BIO_OFS_OPTION); check(rd, 32'h0);
      // One analog line per pattern; lines 0-3 inputs, 4-7 outputs
      for (int i = 0; i < 2; i++) begin
         ext_en <= 8'h0F; ext_val <= 8'h06;
         axi_write(BIO_OFS_DIR, 32'hF0);
         axi_write(BIO_OFS_OPTION, 32'hCC);
         axi_write(BIO_OFS_LEVEL, 32'(p_lvl[i]));
         repeat (6) @(posedge aclk);
         check(32'(pin_pullup & 8'h0F), 32'(p_pu[i]));
         check(32'(analog_sel), 32'(p_an[i]));
         check(32'(pin_oe), 32'(p_oe[i]));
         check(32'(pin_out & 8'hC0), 32'(p_out[i]));
         axi_read(BIO_OFS_DIR); check(rd, 32'hF0);
         axi_read(BIO_OFS_OPTION); check(rd, 32'hCC);
         axi_read(BIO_OFS_LEVEL); check(rd, 32'(8'h06 | (p_lvl[i] & 8'hF0)));
         axi_read(BIO_OFS_PINS); check(rd & 32'h0000_000F, 32'h06);
      end
      // Line 2 is now an input with pull-up and interrupt
      axi_write(BIO_OFS_IRQCFG, 32'h0);
      axi_write(BIO_OFS_IRQSTAT, 32'hFF);
      wait_irq(1'b0);
      ext_val <= 8'h02;
      wait_irq(1'b1);
      axi_read(BIO_OFS_IRQSTAT); check(rd, 32'h04);
      axi_write(BIO_OFS_IRQSTAT, 32'h04);
      wait_irq(1'b0);
      axi_write(BIO_OFS_IRQCFG, 32'h2);
      axi_read(BIO_OFS_IRQCFG); check(rd, 32'h2);
      ext_val <= 8'h06;
      wait_irq(1'b1);
      axi_write(BIO_OFS_IRQSTAT, 32'h04);
      axi_write(BIO_OFS_IRQCFG, 32'h1);
      wait_irq(1'b0);
      ext_val <= 8'h02;
      wait_irq(1'b1);
      ext_val <= 8'h06;
      wait_irq(1'b0);
      // PWM takes line 7, which the latch holds high
      pwm_en <= 1'b1; pwm_val <= 1'b1;
      repeat (3) @(posedge aclk);
      check(32'({pin_oe[7], pin_out[7]}), 32'h3);
      pwm_val <= 1'b0;
      repeat (3) @(posedge aclk);
      check(32'({pin_oe[7], pin_out[7]}), 32'h2);
      axi_read(BIO_OFS_PWM); check(rd, 32'h1);
      pwm_en <= 1'b0;
      axi_read(8'h1C); check({resp, rd[29:0]}, {BIO_RESP_SLVERR, 30'h0});
      axi_write(8'h1C, 32'hFF); check(32'(resp), 32'(BIO_RESP_SLVERR));
      do_reset();
      check(32'(pin_pullup), 32'hFF);
      axi_read(BIO_OFS_DIR); check(rd, 32'h0);
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      finish_test();
   end
endmodule // test_bio_port
